// ### common/ucd_defines.vh
`ifndef UCD_DEFINES_VH
`define UCD_DEFINES_VH
// Avalon word addresses of the registers.
`define UCD_ADDR_COMMAND   2'h0
`define UCD_ADDR_STATUS    2'h1
`define UCD_ADDR_ISR       2'h2
`define UCD_ADDR_STATE     2'h3
// Command register fields.
`define UCD_MISC_HI        6
`define UCD_MISC_LO        4
`define UCD_TXC_HI         3
`define UCD_TXC_LO         2
`define UCD_RXC_HI         1
`define UCD_RXC_LO         0
// Miscellaneous commands.
`define UCD_MISC_NONE      3'h0
`define UCD_MISC_MRPTR     3'h1
`define UCD_MISC_RXRST     3'h2
`define UCD_MISC_TXRST     3'h3
`define UCD_MISC_ERRRST    3'h4
`define UCD_MISC_DBRST     3'h5
`define UCD_MISC_BRKSTART  3'h6
`define UCD_MISC_BRKSTOP   3'h7
// Transmitter and receiver commands.
`define UCD_EN_NONE        2'h0
`define UCD_EN_ENABLE      2'h1
`define UCD_EN_DISABLE     2'h2
// Status register bit positions.
`define UCD_ST_RB          7
`define UCD_ST_FE          6
`define UCD_ST_PE          5
`define UCD_ST_OE          4
`define UCD_ST_TX_EMPTY_FLAG       3
`define UCD_ST_TX_HOLDING_READY_FLAG       2
`define UCD_ST_RX_FIFO_FULL_FLAG       1
`define UCD_ST_RX_CHAR_READY_FLAG       0
// Interrupt status bit position of the delta-break flag.
`define UCD_ISR_DB         2
// Reset values.
`define UCD_STATUS_RST     8'h00
`define UCD_ISR_RST        8'h00
`endif

// ### verilog/ucd_command_decoder.v
// Summary of operation
// - Bits six to four: one command, 000 none.
// - Code 001 points mode pointer at first.
// - Code 010 resets receiver, flags, FIFO pointer.
// - Code 011 disables transmitter, clears empty/ready.
// - Code 100 clears break and error flags.
// - Code 101 clears delta-break flag.
// - Code 110 starts break after current character.
// - Break accepted only with transmitter enabled.
// - Code 111 ends break, resumes sending.
// - Bits three to two: 00 keeps transmitter.
// - Code 01 enables transmitter, sets empty/ready.
// - Code 10 disables transmitter after current character.
// - Receiver 01 enables, start search unless multidrop.
// - Receiver 10 disables, keeps flags; loopback and multidrop override.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "ucd_defines.vh"
module ucd_command_decoder (
    input  wire       ref_clk,          // Bus clock, 100 MHz.
    input  wire       rstn,             // Asynchronous reset, active low.
    input  wire [1:0] avs_address,      // Word address.
    input  wire       avs_read,         // Read request.
    input  wire       avs_write,        // Write request.
    input  wire [7:0] avs_writedata,    // Write data.
    output reg  [7:0] avs_readdata,     // Read data.
    output reg        avs_waitrequest,  // Stall until the answer.
    input  wire       set_rx_ready,     // Receiver stored a character.
    input  wire       set_rx_full,      // Receive FIFO became full.
    input  wire       set_rx_break,     // Received break.
    input  wire       set_framing_err,  // Framing error seen.
    input  wire       set_parity_err,   // Parity error seen.
    input  wire       set_overrun_err,  // Overrun error seen.
    input  wire       set_delta_break,  // Break state changed.
    input  wire       set_tx_ready,     // Holding register moved on.
    input  wire       set_tx_empty,     // Shifter ran dry.
    input  wire       clr_tx_ready,     // Holding register loaded.
    input  wire       clr_tx_empty,     // Shifter started a character.
    input  wire       tx_shift_busy,    // Shifter is sending a character.
    input  wire       tx_bit_tick,      // One pulse per transmit bit time.
    input  wire       multidrop_mode,   // Mode is multidrop.
    input  wire       loopback_mode,    // Mode is local loopback.
    output reg        mode_ptr_reset,   // Pulse: point at first mode reg.
    output reg        rx_fifo_ptr_reset,// Pulse: reinitialise FIFO pointer.
    output reg        rx_search_start,  // Pulse: hunt for a start bit.
    output reg        rx_discard,       // Pulse: drop partial character.
    output reg        rx_enabled,       // Receiver runs.
    output reg        tx_enabled,       // Transmitter accepts characters.
    output reg        tx_active,        // Transmitter shifts.
    output reg        tx_break_hold,    // Shifter must pause for break.
    output reg        txd_break_low,    // Forces the transmit line low.
    output reg  [7:0] channel_status_reg,   // Status flags.
    output reg  [7:0] interrupt_status_reg  // Interrupt status flags.
);

    localparam BRK_IDLE = 2'h0;
    localparam BRK_WAIT = 2'h1;
    localparam BRK_ON   = 2'h2;
    localparam BRK_END  = 2'h3;

    function [2:0] field3;
        input [7:0] d;
        field3 = d[`UCD_MISC_HI:`UCD_MISC_LO];
    endfunction

    function [1:0] field2;
        input [7:0] d;
        input       tx;
        field2 = tx ? d[`UCD_TXC_HI:`UCD_TXC_LO]
                    : d[`UCD_RXC_HI:`UCD_RXC_LO];
    endfunction

    reg        answered;
    reg  [1:0] brk_state;
    reg        tx_stop_pending;

    wire       take   = (avs_read | avs_write) & ~answered;
    wire       cmd_wr = take & avs_write &
                        (avs_address == `UCD_ADDR_COMMAND);
    wire [2:0] misc   = cmd_wr ? field3(avs_writedata) : `UCD_MISC_NONE;
    wire [1:0] txc    = cmd_wr ? field2(avs_writedata, 1'b1)
                               : `UCD_EN_NONE;
    wire [1:0] rxc    = cmd_wr ? field2(avs_writedata, 1'b0)
                               : `UCD_EN_NONE;

    wire tx_reset = (misc == `UCD_MISC_TXRST);
    wire tx_on    = (txc == `UCD_EN_ENABLE) & ~tx_enabled;
    wire tx_off   = (txc == `UCD_EN_DISABLE) & tx_enabled;
    wire rx_reset = (misc == `UCD_MISC_RXRST);

    // Bus slave: every access is answered one cycle after it is taken.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            answered        <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 8'h00;
        end else begin
            answered        <= take;
            avs_waitrequest <= ~take;
            if (take & avs_read) begin
                case (avs_address)
                    `UCD_ADDR_STATUS: avs_readdata <= channel_status_reg;
                    `UCD_ADDR_ISR:    avs_readdata <= interrupt_status_reg;
                    `UCD_ADDR_STATE:  avs_readdata <= {3'h0, txd_break_low,
                        tx_active, tx_enabled, rx_enabled, 1'b0};
                    default:          avs_readdata <= 8'h00;
                endcase
            end
        end
    end

    // Command pulses last exactly the cycle after the write is taken.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ptr_reset    <= 1'b0;
            rx_fifo_ptr_reset <= 1'b0;
            rx_search_start   <= 1'b0;
            rx_discard        <= 1'b0;
        end else begin
            mode_ptr_reset    <= (misc == `UCD_MISC_MRPTR);
            rx_fifo_ptr_reset <= rx_reset;
            rx_search_start   <= (rxc == `UCD_EN_ENABLE) & ~rx_enabled &
                                 ~multidrop_mode;
            rx_discard        <= rx_reset |
                                 ((rxc == `UCD_EN_DISABLE) & rx_enabled);
        end
    end

    // Loopback and multidrop keep the receiver running regardless.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_enabled <= 1'b0;
        end else if (rx_reset) begin
            rx_enabled <= loopback_mode | multidrop_mode;
        end else if (rxc == `UCD_EN_ENABLE && !multidrop_mode) begin
            rx_enabled <= 1'b1;
        end else if (rxc == `UCD_EN_DISABLE) begin
            rx_enabled <= loopback_mode | multidrop_mode;
        end else if (loopback_mode | multidrop_mode) begin
            rx_enabled <= 1'b1;
        end
    end

    // A disable lets the character in the shifter finish first.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_enabled      <= 1'b0;
            tx_active       <= 1'b0;
            tx_stop_pending <= 1'b0;
        end else begin
            if (tx_reset || tx_off) begin
                tx_enabled <= 1'b0;
            end else if (tx_on) begin
                tx_enabled <= 1'b1;
            end
            if (tx_on) begin
                tx_active       <= 1'b1;
                tx_stop_pending <= 1'b0;
            end else if (tx_reset || tx_off) begin
                tx_stop_pending <= tx_shift_busy;
                tx_active       <= tx_shift_busy;
            end else if (tx_stop_pending && !tx_shift_busy) begin
                tx_stop_pending <= 1'b0;
                tx_active       <= 1'b0;
            end
        end
    end

    // Hardware sets win over the error, receiver and delta-break clears in the same cycle; transmitter commands override the tx flag updates.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            channel_status_reg   <= `UCD_STATUS_RST;
            interrupt_status_reg <= `UCD_ISR_RST;
        end else begin
            if (misc == `UCD_MISC_ERRRST) begin
                channel_status_reg[`UCD_ST_RB] <= set_rx_break;
                channel_status_reg[`UCD_ST_FE] <= set_framing_err;
                channel_status_reg[`UCD_ST_PE] <= set_parity_err;
                channel_status_reg[`UCD_ST_OE] <= set_overrun_err;
            end else begin
                if (set_rx_break)
                    channel_status_reg[`UCD_ST_RB] <= 1'b1;
                if (set_framing_err)
                    channel_status_reg[`UCD_ST_FE] <= 1'b1;
                if (set_parity_err)
                    channel_status_reg[`UCD_ST_PE] <= 1'b1;
                if (set_overrun_err)
                    channel_status_reg[`UCD_ST_OE] <= 1'b1;
            end
            if (rx_reset) begin
                channel_status_reg[`UCD_ST_RX_FIFO_FULL_FLAG] <= set_rx_full;
                channel_status_reg[`UCD_ST_RX_CHAR_READY_FLAG] <= set_rx_ready;
            end else begin
                if (set_rx_full)
                    channel_status_reg[`UCD_ST_RX_FIFO_FULL_FLAG] <= 1'b1;
                if (set_rx_ready)
                    channel_status_reg[`UCD_ST_RX_CHAR_READY_FLAG] <= 1'b1;
            end
            if (tx_on) begin
                channel_status_reg[`UCD_ST_TX_EMPTY_FLAG] <= 1'b1;
                channel_status_reg[`UCD_ST_TX_HOLDING_READY_FLAG] <= 1'b1;
            end else if (tx_reset || tx_off) begin
                channel_status_reg[`UCD_ST_TX_EMPTY_FLAG] <= 1'b0;
                channel_status_reg[`UCD_ST_TX_HOLDING_READY_FLAG] <= 1'b0;
            end else begin
                if (set_tx_empty)
                    channel_status_reg[`UCD_ST_TX_EMPTY_FLAG] <= 1'b1;
                else if (clr_tx_empty)
                    channel_status_reg[`UCD_ST_TX_EMPTY_FLAG] <= 1'b0;
                if (set_tx_ready)
                    channel_status_reg[`UCD_ST_TX_HOLDING_READY_FLAG] <= 1'b1;
                else if (clr_tx_ready)
                    channel_status_reg[`UCD_ST_TX_HOLDING_READY_FLAG] <= 1'b0;
            end
            if (misc == `UCD_MISC_DBRST)
                interrupt_status_reg[`UCD_ISR_DB] <= set_delta_break;
            else if (set_delta_break)
                interrupt_status_reg[`UCD_ISR_DB] <= 1'b1;
        end
    end

    // Break sequencer. Waiting for a bit tick when idle gives the up to
    // one bit time start delay; the stop waits for one bit tick at most.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            brk_state     <= BRK_IDLE;
            txd_break_low <= 1'b0;
            tx_break_hold <= 1'b0;
        end else begin
            case (brk_state)
                BRK_IDLE: begin
                    if (misc == `UCD_MISC_BRKSTART && tx_enabled) begin
                        brk_state     <= BRK_WAIT;
                        tx_break_hold <= 1'b1;
                    end
                end
                BRK_WAIT: begin
                    if (misc == `UCD_MISC_BRKSTOP) begin
                        brk_state     <= BRK_IDLE;
                        tx_break_hold <= 1'b0;
                    end else if (!tx_shift_busy && tx_bit_tick) begin
                        brk_state     <= BRK_ON;
                        txd_break_low <= 1'b1;
                    end
                end
                BRK_ON: begin
                    if (misc == `UCD_MISC_BRKSTOP) begin
                        brk_state <= BRK_END;
                    end
                end
                BRK_END: begin
                    if (tx_bit_tick) begin
                        txd_break_low <= 1'b0;
                        brk_state     <= BRK_IDLE;
                        tx_break_hold <= 1'b0;
                    end
                end
                default: begin
                    brk_state <= BRK_IDLE;
                end
            endcase
        end
    end

endmodule // ucd_command_decoder

// ### test/ucd_checker_sva.sv
`timescale 1ns/1ns
module ucd_checker (
    input wire       ref_clk,              // Clock.
    input wire       rstn,                 // Reset, active low.
    input wire [1:0] avs_address,          // Address.
    input wire       avs_read,             // Read.
    input wire       avs_write,            // Write.
    input wire [7:0] avs_writedata,        // Write data.
    input wire       avs_waitrequest,      // Stall.
    input wire       loopback_mode,        // Loopback.
    input wire       multidrop_mode,       // Multidrop.
    input wire       mode_ptr_reset,       // Pointer pulse.
    input wire       rx_fifo_ptr_reset,    // FIFO pulse.
    input wire       rx_discard,           // Discard pulse.
    input wire       rx_search_start,      // Start search pulse.
    input wire       tx_active,            // Transmitter shifting.
    input wire       rx_enabled,           // Receiver on.
    input wire       tx_enabled,           // Transmitter on.
    input wire       txd_break_low,        // Break.
    input wire [7:0] channel_status_reg,   // Status.
    input wire [7:0] interrupt_status_reg  // Interrupt status.
);
    // A request seen with waitrequest high is the cycle it is taken.
    wire       cw = avs_write && avs_waitrequest && avs_address == 2'h0;
    wire [2:0] mc = avs_writedata[6:4];
    wire [1:0] tc = avs_writedata[3:2];
    wire [1:0] rc = avs_writedata[1:0];
    wire       kp = loopback_mode || multidrop_mode;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer");
    ptr_pulse_a: assert property (cw && mc == 3'h1
        |=> mode_ptr_reset ##1 !mode_ptr_reset) else $error("pointer pulse");
    rx_reset_a: assert property (cw && mc == 3'h2 |=> rx_fifo_ptr_reset
        && channel_status_reg[1:0] == 2'h0 && (kp || !rx_enabled))
        else $error("receiver reset");
    tx_reset_a: assert property (cw && mc == 3'h3
        |=> !tx_enabled && channel_status_reg[3:2] == 2'h0) else $error("tx reset");
    err_clr_a: assert property (cw && mc == 3'h4
        |=> channel_status_reg[7:4] == 4'h0) else $error("error clear");
    db_clr_a: assert property (cw && mc == 3'h5
        |=> !interrupt_status_reg[2]) else $error("delta break clear");
    tx_keep_a: assert property (cw && tc == 2'h0 && mc != 3'h3
        |=> $stable(tx_enabled)) else $error("tx keep");
    tx_on_a: assert property (cw && tc == 2'h1 && !tx_enabled
        |=> tx_enabled && channel_status_reg[3:2] == 2'h3) else $error("tx on");
    tx_off_a: assert property (cw && tc == 2'h2 && tx_enabled
        |=> !tx_enabled && channel_status_reg[3:2] == 2'h0) else $error("tx off");
    rx_off_a: assert property (cw && rc == 2'h2 && rx_enabled && !kp
        |=> !rx_enabled && rx_discard) else $error("rx off");
    brk_stop_a: assert property (cw && mc == 3'h7
        |=> ##[0:34] !txd_break_low) else $error("break stop");
    brk_ign_a: assert property (cw && mc == 3'h6 && !tx_enabled && tc != 2'h1 &&
        !txd_break_low |=> !txd_break_low [*8]) else $error("break ignored");
    rx_search_a: assert property (cw && rc == 2'h1 && !rx_enabled
        && !multidrop_mode |=> rx_search_start) else $error("rx search");
    tx_act_a: assert property (cw && tc == 2'h1 && !tx_enabled
        |=> tx_active) else $error("tx active");
    cover property (cw && mc == 3'h2);
    cover property (cw && tc == 2'h1 && !tx_enabled);
    cover property ($rose(txd_break_low));
endmodule // ucd_checker
bind ucd_command_decoder ucd_checker u_chk (.*);

// ### test/ucd_link_model.sv
`timescale 1ns/1ns
module ucd_link_model (
    input  wire ref_clk,       // Clock.
    input  wire rstn,          // Reset, active low.
    input  wire send,          // Start one character.
    input  wire tx_break_hold, // Shifter paused.
    output reg  tx_bit_tick,   // Bit time pulse.
    output reg  tx_shift_busy  // Character in flight.
);
    reg [3:0] div;
    reg [3:0] bits;
    // A bit time is sixteen clocks so break timing shows in a short run.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div <= 4'h0;
            bits <= 4'h0;
            tx_bit_tick <= 1'b0;
            tx_shift_busy <= 1'b0;
        end else begin
            div <= div + 4'h1;
            tx_bit_tick <= (div == 4'hF);
            if (send && !tx_shift_busy && !tx_break_hold) begin
                bits <= 4'hA;
                tx_shift_busy <= 1'b1;
            end else if (tx_bit_tick && bits != 4'h0) begin
                bits <= bits - 4'h1;
                tx_shift_busy <= (bits != 4'h1);
            end
        end
    end
endmodule // ucd_link_model

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench;
    reg         ref_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, send = 0;
    reg         lb = 0, md = 0;
    reg  [1:0]  avs_address = 2'h0;
    reg  [7:0]  avs_writedata = 8'h00, d, c;
    reg  [10:0] pv = 11'h000, v, s;
    wire [7:0]  avs_readdata, st, isr;
    wire        avs_waitrequest, mpr, rxe, txe, tact, hold, brk, tick, busy;
    integer     mismatches = 0, cmp_count = 0, cyc = 0, i, nmp = 0, emp = 0;
    ucd_command_decoder DUT (.ref_clk(ref_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .set_rx_ready(pv[0]),
        .set_rx_full(pv[1]), .set_rx_break(pv[2]), .set_framing_err(pv[3]),
        .set_parity_err(pv[4]), .set_overrun_err(pv[5]),
        .set_delta_break(pv[6]), .set_tx_ready(pv[7]), .set_tx_empty(pv[8]),
        .clr_tx_ready(pv[9]), .clr_tx_empty(pv[10]), .tx_shift_busy(busy),
        .tx_bit_tick(tick), .multidrop_mode(md), .loopback_mode(lb),
        .mode_ptr_reset(mpr), .rx_fifo_ptr_reset(), .rx_search_start(),
        .rx_discard(), .rx_enabled(rxe), .tx_enabled(txe), .tx_active(tact),
        .tx_break_hold(hold), .txd_break_low(brk), .channel_status_reg(st),
        .interrupt_status_reg(isr));
    ucd_link_model u_link (.ref_clk(ref_clk), .rstn(rstn), .send(send),
        .tx_break_hold(hold), .tx_bit_tick(tick), .tx_shift_busy(busy));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (mpr === 1'b1) nmp = nmp + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string n, input [7:0] e, input [7:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("mismatch %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task bus(input w, input [1:0] a, input [7:0] wd);
        begin
            @(posedge ref_clk);
            avs_write <= w;
            avs_read <= !w;
            avs_address <= a;
            avs_writedata <= wd;
            // Look between edges so the answer is read where it is settled.
            @(negedge ref_clk);
            while (avs_waitrequest !== 1'b0) @(negedge ref_clk);
            d = avs_readdata;
            @(posedge ref_clk);
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task state_chk;
        begin
            bus(0, 2'h1, 8'h00); chk("status", s[9:2], d);
            bus(0, 2'h2, 8'h00); chk("isr", {5'h0, s[10], 2'h0}, d);
            bus(0, 2'h3, 8'h00); chk("state", {5'h0, s[1:0], 1'b0}, d & 8'h06);
        end
    endtask
    // Packed state: delta break, eight status bits, tx enabled, rx enabled.
    function [10:0] fl(input [10:0] q, input [10:0] p);
        begin
            fl = q | {p[6], p[2], p[3], p[4], p[5], p[8], p[7], p[1:0], 2'h0};
            fl[5] = fl[5] & (~p[10] | p[8]);
            fl[4] = fl[4] & (~p[9] | p[7]);
        end
    endfunction
    function [10:0] cm(input [10:0] q, input [7:0] k, input kp, input m);
        begin
            cm = q;
            case (k[6:4])
                3'h2: begin cm[3:2] = 2'h0; if (!kp) cm[0] = 1'b0; end
                3'h3: begin cm[1] = 1'b0; cm[5:4] = 2'h0; end
                3'h4: cm[9:6] = 4'h0;
                3'h5: cm[10] = 1'b0;
                default: ;
            endcase
            if (k[3:2] == 2'h1 && !q[1]) begin
                cm[5:4] = 2'h3;
                cm[1] = 1'b1;
            end
            if (k[3:2] == 2'h2 && q[1]) begin
                cm[5:4] = 2'h0;
                cm[1] = 1'b0;
            end
            if (k[1:0] == 2'h1 && !m) cm[0] = 1'b1;
            if (k[1:0] == 2'h2 && !kp) cm[0] = 1'b0;
            // Loopback and multidrop keep the receiver running.
            if (kp) cm[0] = 1'b1;
        end
    endfunction
    initial begin
        i = $urandom(32'h753c);
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        s = 11'h000;
        bus(0, 2'h0, 8'h00); chk("command read", 8'h00, d);
        state_chk;
        $display("test reset done");
        for (i = 0; i < 40; i = i + 1) begin
            v = $urandom;
            v[8:7] = v[8:7] & {2{s[1]}};
            @(posedge ref_clk);
            pv <= v;
            lb <= $urandom % 2;
            md <= $urandom % 2;
            @(posedge ref_clk);
            pv <= 11'h000;
            s = fl(s, v);
            c = $urandom;
            c[7] = 1'b0;
            if (c[3:2] == 2'h3) c[3:2] = 2'h0;
            if (c[1:0] == 2'h3) c[1:0] = 2'h0;
            if (c[6:4] > 3'h5) c[6:4] = 3'h1;
            if (c[6:4] == 3'h3 && c[3:2] == 2'h1) c[3:2] = 2'h0;
            if (c[6:4] == 3'h2 && c[1:0] == 2'h1) c[1:0] = 2'h0;
            if (c[6:4] == 3'h1) emp = emp + 1;
            bus(1, 2'h0, c);
            s = cm(s, c, lb | md, md);
            state_chk;
        end
        chk("pointer pulses", emp[7:0], nmp[7:0]);
        $display("test commands done");
        bus(1, 2'h0, 8'h04);
        @(posedge ref_clk);
        send <= 1'b1;
        @(posedge ref_clk);
        send <= 1'b0;
        bus(1, 2'h0, 8'h60);
        chk("break early", 8'h00, {7'h0, brk & busy});
        for (i = 0; i < 400 && brk !== 1'b1; i = i + 1) @(posedge ref_clk);
        chk("break on", 8'h01, {7'h0, brk});
        bus(1, 2'h0, 8'h70);
        for (i = 0; i < 400 && brk !== 1'b0; i = i + 1) @(posedge ref_clk);
        chk("break off", 8'h01, {7'h0, i <= 34});
        bus(1, 2'h0, 8'h08);
        bus(1, 2'h0, 8'h60);
        repeat (34) @(posedge ref_clk);
        chk("break refused", 8'h00, {7'h0, brk});
        $display("test break done");
        test_done;
    end
endmodule // testbench
